// *** common/rtc_alarm_pkg.sv ***
// Constants and types shared by the real-time clock alarm and control block.
package rtc_alarm_pkg;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_ALARM_SEC = 8'he8;
    localparam logic [7:0] IDX_ALARM_MIN = 8'he9;
    localparam logic [7:0] IDX_ALARM_HOUR = 8'hea;
    localparam logic [7:0] IDX_ALARM_WEEKDAY = 8'heb;
    localparam logic [7:0] IDX_ALARM_EN = 8'hec;
    localparam logic [7:0] IDX_CTRL = 8'hed;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hee;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hef;
    localparam int ADR_W = 10;

    // ------------------------------------------------------------------
    // Control register fields.
    // ------------------------------------------------------------------
    localparam int CTRL_ALARM = 7;
    localparam int CTRL_INT_EN = 6;
    localparam int CTRL_BCD = 5;
    localparam int CTRL_CLK_SEL = 4;
    localparam int CTRL_MAINS_RATE = 3;
    localparam int CTRL_WAKE = 1;
    localparam int CTRL_UNLOCK = 0;

    // ------------------------------------------------------------------
    // Alarm enable and interrupt fields, reset values.
    // ------------------------------------------------------------------
    localparam int EN_SEC = 0;
    localparam int EN_MIN = 1;
    localparam int EN_HOUR = 2;
    localparam int EN_WEEKDAY = 3;
    localparam int NUM_FIELDS = 4;
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_WAKE = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] RESET_NIBBLE = 4'h0;
    localparam logic [1:0] RESET_IRQ = 2'h0;

    // ------------------------------------------------------------------
    // Prescaler divisors in source edges per second.
    // ------------------------------------------------------------------
    localparam logic [15:0] DIV_XTAL = 16'h8000;
    localparam logic [15:0] DIV_MAINS_60 = 16'h003c;
    localparam logic [15:0] DIV_MAINS_50 = 16'h0032;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;

endpackage

// *** core/rtc_tick_gen.sv ***
// Seconds prescaler fed by the crystal or mains input pin.
module rtc_tick_gen (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Time source pins
    input wire logic i_xtal,
    input wire logic i_mains,
    // Control
    input wire logic i_clk_sel,
    input wire logic i_mains_rate,
    input wire logic i_clear,
    input wire logic i_run,
    // Tick out
    output logic o_tick
);
    import rtc_alarm_pkg::*;

    logic [2:0] xtal_sync;
    logic [2:0] mains_sync;
    logic [15:0] count;
    logic [15:0] divisor;
    logic edge_seen;

    // Only the second and third stages are looked at.
    always_ff @(posedge i_clk) begin
        xtal_sync <= {xtal_sync[1:0], i_xtal};
        mains_sync <= {mains_sync[1:0], i_mains};
    end

    assign divisor = i_clk_sel ? (i_mains_rate ? DIV_MAINS_50 : DIV_MAINS_60) : DIV_XTAL;
    assign edge_seen = i_clk_sel ? (mains_sync[1] & ~mains_sync[2]) : (xtal_sync[1] & ~xtal_sync[2]);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            count <= 16'h0000;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (edge_seen && i_run) begin
                if (count == divisor - 16'h0001) begin
                    count <= 16'h0000;
                    o_tick <= 1'b1;
                end else begin
                    count <= count + 16'h0001;
                end
            end
        end
    end
endmodule

// *** core/rtc_alarm_match.sv ***
// Compares the enabled alarm set points with the current time.
module rtc_alarm_match (
    // Set points and enables
    input wire logic [7:0] i_alarm_sec,
    input wire logic [7:0] i_alarm_min,
    input wire logic [7:0] i_alarm_hour,
    input wire logic [3:0] i_alarm_weekday,
    input wire logic [3:0] i_enables,
    // Current time
    input wire logic [7:0] i_now_sec,
    input wire logic [7:0] i_now_min,
    input wire logic [7:0] i_now_hour,
    input wire logic [7:0] i_now_weekday,
    // Result
    output logic o_match
);
    import rtc_alarm_pkg::*;

    logic [NUM_FIELDS-1:0] field_ok;
    logic [NUM_FIELDS-1:0] field_eq;

    assign field_eq[EN_SEC] = (i_alarm_sec == i_now_sec);
    assign field_eq[EN_MIN] = (i_alarm_min == i_now_min);
    assign field_eq[EN_HOUR] = (i_alarm_hour == i_now_hour);
    assign field_eq[EN_WEEKDAY] = ({4'h0, i_alarm_weekday} == i_now_weekday);

    // A disabled field never blocks a match.
    genvar g;
    generate
        for (g = 0; g < NUM_FIELDS; g = g + 1) begin : g_field
            assign field_ok[g] = ~i_enables[g] | field_eq[g];
        end
    endgenerate

    assign o_match = (|i_enables) & (&field_ok);
endmodule

// *** core/rtc_alarm_ctrl.sv ***
// Top of the real-time clock alarm, alarm enable and control/status registers.
//
// Chosen here: register access over Wishbone.

module rtc_alarm_ctrl (
    // Clock and resets
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_PWR_ON_N,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [rtc_alarm_pkg::ADR_W-1:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Time source pins
    input wire logic I_XTAL,
    input wire logic I_MAINS,
    // Current time from the counters
    input wire logic I_COUNT_STEP,
    input wire logic [7:0] I_NOW_SEC,
    input wire logic [7:0] I_NOW_MIN,
    input wire logic [7:0] I_NOW_HOUR,
    input wire logic [7:0] I_NOW_WEEKDAY,
    input wire logic I_SLEEPING,
    // Counter and oscillator control
    output logic O_SECOND_TICK,
    output logic O_COUNT_ENABLE,
    output logic O_BCD_MODE,
    output logic O_OSC_ENABLE,
    output logic O_WAKE_RESET,
    // Interrupt
    output logic O_IRQ
);
    import rtc_alarm_pkg::*;

    // ------------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------------
    bus_state_t bus_state;
    logic [7:0] alarm_seconds;
    logic [7:0] alarm_minutes;
    logic [7:0] alarm_hours;
    logic [3:0] alarm_weekday_value;
    logic [3:0] alarm_enables;
    logic alarm_flag;
    logic int_enable;
    logic bcd_mode;
    logic clk_sel;
    logic mains_rate_select;
    logic sleep_wake_cause;
    logic clock_unlocked;
    logic [1:0] irq_mask;
    logic [1:0] irq_status;
    logic [7:0] idx;
    logic access;
    logic wr_low;
    logic rd;
    logic [7:0] wdat;
    logic [7:0] next_rdata;
    logic match;
    logic lock_event;
    logic alarm_event;
    logic wr_ctrl;
    logic rd_ctrl;

    assign idx = I_WB_ADR[ADR_W-1:2];
    // The answer comes one cycle after the request; access is the taking edge.
    assign access = I_WB_CYC & I_WB_STB & (bus_state == BUS_IDLE);
    assign wr_low = access & I_WB_WE & I_WB_SEL[0];
    assign rd = access & ~I_WB_WE;
    assign wdat = I_WB_DAT[7:0];
    assign wr_ctrl = wr_low & (idx == IDX_CTRL);
    assign rd_ctrl = rd & (idx == IDX_CTRL);

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            bus_state <= BUS_IDLE;
            O_WB_ACK <= 1'b0;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (I_WB_CYC && I_WB_STB) begin
                        bus_state <= BUS_ACK;
                        O_WB_ACK <= 1'b1;
                    end
                end
                BUS_ACK: begin
                    bus_state <= BUS_IDLE;
                    O_WB_ACK <= 1'b0;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                    O_WB_ACK <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = RESET_BYTE;
        case (idx)
            IDX_ALARM_SEC: begin
                next_rdata = alarm_seconds;
            end
            IDX_ALARM_MIN: begin
                next_rdata = alarm_minutes;
            end
            IDX_ALARM_HOUR: begin
                next_rdata = alarm_hours;
            end
            IDX_ALARM_WEEKDAY: begin
                next_rdata = {4'h0, alarm_weekday_value};
            end
            IDX_ALARM_EN: begin
                next_rdata = {4'h0, alarm_enables};
            end
            IDX_CTRL: begin
                next_rdata[CTRL_ALARM] = alarm_flag;
                next_rdata[CTRL_INT_EN] = int_enable;
                next_rdata[CTRL_BCD] = bcd_mode;
                next_rdata[CTRL_CLK_SEL] = clk_sel;
                next_rdata[CTRL_MAINS_RATE] = mains_rate_select;
                next_rdata[CTRL_WAKE] = sleep_wake_cause;
                next_rdata[CTRL_UNLOCK] = clock_unlocked;
            end
            IDX_IRQ_MASK: begin
                next_rdata = {6'h00, irq_mask};
            end
            IDX_IRQ_STATUS: begin
                next_rdata = {6'h00, irq_status};
            end
            default: begin
                next_rdata = RESET_BYTE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_WB_DAT <= 32'h00000000;
        end else if (rd) begin
            O_WB_DAT <= {24'h000000, next_rdata};
        end else begin
            O_WB_DAT <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // Alarm set points
    // ------------------------------------------------------------------
    // The system reset is not applied here, so a wake-up reset keeps the alarm time.
    always_ff @(posedge I_CLOCK) begin
        if (!I_PWR_ON_N) begin
            alarm_seconds <= RESET_BYTE;
            alarm_minutes <= RESET_BYTE;
            alarm_hours <= RESET_BYTE;
        end else if (wr_low) begin
            if (idx == IDX_ALARM_SEC) begin
                alarm_seconds <= wdat;
            end
            if (idx == IDX_ALARM_MIN) begin
                alarm_minutes <= wdat;
            end
            if (idx == IDX_ALARM_HOUR) begin
                alarm_hours <= wdat;
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_PWR_ON_N) begin
            alarm_weekday_value <= RESET_NIBBLE;
        end else if (wr_low && idx == IDX_ALARM_WEEKDAY && clock_unlocked) begin
            alarm_weekday_value <= wdat[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Alarm enables
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            alarm_enables <= RESET_NIBBLE;
        end else if (wr_low && idx == IDX_ALARM_EN) begin
            alarm_enables <= wdat[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            int_enable <= 1'b0;
            clock_unlocked <= 1'b0;
        end else if (wr_ctrl) begin
            int_enable <= wdat[CTRL_INT_EN];
            clock_unlocked <= wdat[CTRL_UNLOCK];
        end
    end

    // Coding and source selection only fall back on power-up.
    always_ff @(posedge I_CLOCK) begin
        if (!I_PWR_ON_N) begin
            bcd_mode <= 1'b0;
            clk_sel <= 1'b0;
            mains_rate_select <= 1'b0;
        end else if (wr_ctrl) begin
            bcd_mode <= wdat[CTRL_BCD];
            clk_sel <= wdat[CTRL_CLK_SEL];
            mains_rate_select <= wdat[CTRL_MAINS_RATE];
        end
    end

    // ------------------------------------------------------------------
    // Alarm evaluation
    // ------------------------------------------------------------------
    rtc_alarm_match u_match (
        .i_alarm_sec(alarm_seconds),
        .i_alarm_min(alarm_minutes),
        .i_alarm_hour(alarm_hours),
        .i_alarm_weekday(alarm_weekday_value),
        .i_enables(alarm_enables),
        .i_now_sec(I_NOW_SEC),
        .i_now_min(I_NOW_MIN),
        .i_now_hour(I_NOW_HOUR),
        .i_now_weekday(I_NOW_WEEKDAY),
        .o_match(match)
    );

    assign lock_event = wr_ctrl & clock_unlocked & ~wdat[CTRL_UNLOCK];
    assign alarm_event = (I_COUNT_STEP | lock_event) & match;

    // A new alarm in the same cycle as the clearing read wins over the read.
    always_ff @(posedge I_CLOCK) begin
        if (!I_PWR_ON_N) begin
            alarm_flag <= 1'b0;
        end else if (alarm_event) begin
            alarm_flag <= 1'b1;
        end else if (rd_ctrl) begin
            alarm_flag <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_PWR_ON_N) begin
            sleep_wake_cause <= 1'b0;
        end else if (alarm_event && I_SLEEPING) begin
            sleep_wake_cause <= 1'b1;
        end else if (rd_ctrl) begin
            sleep_wake_cause <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_WAKE_RESET <= 1'b0;
        end else begin
            O_WAKE_RESET <= alarm_event & I_SLEEPING;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            irq_mask <= RESET_IRQ;
        end else if (wr_low && idx == IDX_IRQ_MASK) begin
            irq_mask <= wdat[1:0];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            irq_status <= RESET_IRQ;
        end else begin
            if (alarm_event && int_enable) begin
                irq_status[IRQ_ALARM] <= 1'b1;
            end else if (rd_ctrl || (rd && idx == IDX_IRQ_STATUS)) begin
                irq_status[IRQ_ALARM] <= 1'b0;
            end
            if (alarm_event && I_SLEEPING) begin
                irq_status[IRQ_WAKE] <= 1'b1;
            end else if (rd && idx == IDX_IRQ_STATUS) begin
                irq_status[IRQ_WAKE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Counter and oscillator control
    // ------------------------------------------------------------------
    rtc_tick_gen u_tick (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_xtal(I_XTAL),
        .i_mains(I_MAINS),
        .i_clk_sel(clk_sel),
        .i_mains_rate(mains_rate_select),
        .i_clear(wr_ctrl),
        .i_run(~clock_unlocked),
        .o_tick(O_SECOND_TICK)
    );

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_COUNT_ENABLE <= 1'b0;
            O_BCD_MODE <= 1'b0;
            O_OSC_ENABLE <= 1'b0;
        end else begin
            O_COUNT_ENABLE <= ~clock_unlocked;
            O_BCD_MODE <= bcd_mode;
            O_OSC_ENABLE <= ~clk_sel;
        end
    end
endmodule

// *** verification/rtc_alarm_ctrl_checker.sv ***
// Concurrent checks on the ports of the real-time clock alarm and control block.
module rtc_alarm_ctrl_checker (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Register bus
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [rtc_alarm_pkg::ADR_W-1:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [31:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    // Status and control
    input wire logic I_SLEEPING,
    input wire logic O_SECOND_TICK,
    input wire logic O_COUNT_ENABLE,
    input wire logic O_BCD_MODE,
    input wire logic O_OSC_ENABLE,
    input wire logic O_WAKE_RESET,
    input wire logic O_IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_alarm_pkg::*;

    // ------------------------------------------------------------------
    // Helper logic.
    // ------------------------------------------------------------------
    // The written control byte is kept so that the registered mode outputs can be tied to it later.
    logic take;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    assign ctrl_wr = take && I_WB_WE && I_WB_SEL[0] && I_WB_ADR[9:2] == IDX_CTRL;
    always_ff @(posedge I_CLOCK) begin
        if (ctrl_wr) begin
            ctrl_wdata <= I_WB_DAT[7:0];
        end
    end

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_N);

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    a_ctrl_bit_two: assert property (take && !I_WB_WE && I_WB_ADR[9:2] == IDX_CTRL
        |=> O_WB_ACK && !O_WB_DAT[2]) else $error("control bit 2 read as one");
    a_weekday_upper_zero: assert property (take && !I_WB_WE && I_WB_ADR[9:2] == IDX_ALARM_WEEKDAY
        |=> O_WB_ACK && O_WB_DAT[7:4] == 4'h0) else $error("weekday upper nibble not zero");
    a_enables_upper_zero: assert property (take && !I_WB_WE && I_WB_ADR[9:2] == IDX_ALARM_EN
        |=> O_WB_ACK && O_WB_DAT[7:4] == 4'h0) else $error("enable upper nibble not zero");
    a_count_follows_lock: assert property (ctrl_wr
        |-> ##2 O_COUNT_ENABLE == !ctrl_wdata[CTRL_UNLOCK]) else $error("count enable wrong");
    a_bcd_follows_ctrl: assert property (ctrl_wr
        |-> ##2 O_BCD_MODE == ctrl_wdata[CTRL_BCD]) else $error("bcd mode wrong");
    a_osc_follows_select: assert property (ctrl_wr
        |-> ##2 O_OSC_ENABLE == !ctrl_wdata[CTRL_CLK_SEL]) else $error("oscillator enable wrong");
    a_tick_when_locked: assert property (O_SECOND_TICK |-> O_COUNT_ENABLE)
        else $error("tick while counting stopped");
    a_tick_single_pulse: assert property (O_SECOND_TICK |=> !O_SECOND_TICK [*8])
        else $error("tick too long or too close");
    a_wake_needs_sleep: assert property (O_WAKE_RESET |-> $past(I_SLEEPING))
        else $error("wake reset while awake");

    c_tick: cover property (O_SECOND_TICK);
    c_wake: cover property (O_WAKE_RESET);
    c_irq: cover property (O_IRQ);
    c_flag_read: cover property (O_WB_ACK && O_WB_DAT[CTRL_ALARM]);
endmodule

bind rtc_alarm_ctrl rtc_alarm_ctrl_checker i_checker (
    .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
    .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
    .I_SLEEPING(I_SLEEPING), .O_SECOND_TICK(O_SECOND_TICK), .O_COUNT_ENABLE(O_COUNT_ENABLE),
    .O_BCD_MODE(O_BCD_MODE), .O_OSC_ENABLE(O_OSC_ENABLE), .O_WAKE_RESET(O_WAKE_RESET), .O_IRQ(O_IRQ)
);

// *** verification/rtc_alarm_ctrl_tb.sv ***
// Self-checking bench for the real-time clock alarm and control block.
module rtc_alarm_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_alarm_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus, model state and counters.
    // ------------------------------------------------------------------
    logic clk = '0, rst_n = '0, pwr_n = '0, cyc = '0, stb = '0, we = '0, xtal = '0, mains = '0, step = '0, slp = '0;
    logic [9:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [7:0] nsec = '0, nmin = '0, nhour = '0, nwd = '0;
    logic [31:0] rdat;
    logic ack, tick, cnt_en, bcd, osc_en, wake, irq;
    int mismatches = 0, num_checks = 0, cycles = 0, ticks = 0;
    int alarm_second_ones, alarm_minute_ones, ahour, awd, aen, mctrl, flag, wakec, st, mask;

    rtc_alarm_ctrl i_dut (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_PWR_ON_N(pwr_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_XTAL(xtal),
        .I_MAINS(mains), .I_COUNT_STEP(step), .I_NOW_SEC(nsec), .I_NOW_MIN(nmin), .I_NOW_HOUR(nhour),
        .I_NOW_WEEKDAY(nwd), .I_SLEEPING(slp), .O_SECOND_TICK(tick), .O_COUNT_ENABLE(cnt_en),
        .O_BCD_MODE(bcd), .O_OSC_ENABLE(osc_en), .O_WAKE_RESET(wake), .O_IRQ(irq)
    );

    always #12.5 clk = ~clk;

    // The ceiling is several times the expected run, so only a hang reaches it.
    always @(posedge clk) begin
        cycles++;
        if (tick === 1'b1) ticks++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Reference model.
    // ------------------------------------------------------------------
    function automatic bit hit();
        return aen != 0 && (!aen[0] || nsec == alarm_second_ones) && (!aen[1] || nmin == alarm_minute_ones)
            && (!aen[2] || nhour == ahour) && (!aen[3] || nwd == awd);
    endfunction

    function automatic void fire();
        if (hit()) begin
            flag = 1;
            if (mctrl[6]) st |= 1;
            if (slp) begin
                st |= 2;
                wakec = 1;
            end
        end
    endfunction

    function automatic void mwrite(logic [7:0] idx, int d);
        case (idx)
            IDX_ALARM_SEC: alarm_second_ones = d;
            IDX_ALARM_MIN: alarm_minute_ones = d;
            IDX_ALARM_HOUR: ahour = d;
            IDX_ALARM_WEEKDAY: if (mctrl[0]) awd = d & 8'h0f;
            IDX_ALARM_EN: aen = d & 8'h0f;
            IDX_CTRL: begin
                if (mctrl[0] && !d[0]) fire();
                mctrl = d & 8'h79;
            end
            IDX_IRQ_MASK: mask = d & 8'h03;
            default: ;
        endcase
    endfunction

    function automatic int mread(logic [7:0] idx);
        int v = 0;
        case (idx)
            IDX_ALARM_SEC: v = alarm_second_ones;
            IDX_ALARM_MIN: v = alarm_minute_ones;
            IDX_ALARM_HOUR: v = ahour;
            IDX_ALARM_WEEKDAY: v = awd;
            IDX_ALARM_EN: v = aen;
            IDX_IRQ_MASK: v = mask;
            IDX_CTRL: begin
                v = mctrl | (flag << 7) | (wakec << 1);
                flag = 0;
                wakec = 0;
                st &= ~1;
            end
            IDX_IRQ_STATUS: begin
                v = st;
                st = 0;
            end
            default: ;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Bus, checking and stimulus tasks.
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        q = rdat[7:0];
        check("ack delay", n, 2);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(idx, 1'b1, d, q);
        mwrite(idx, d);
    endtask

    task automatic rd(input logic [7:0] idx);
        logic [7:0] q;
        bus(idx, 1'b0, 8'h00, q);
        check($sformatf("register %h", idx), q, mread(idx));
    endtask

    task automatic mode();
        @(posedge clk);
        check("count enable", cnt_en, !mctrl[0]);
        check("bcd mode", bcd, mctrl[5]);
        check("osc enable", osc_en, !mctrl[4]);
    endtask

    task automatic irqchk();
        @(posedge clk);
        check("irq", irq, (st & mask) != 0);
    endtask

    task automatic evt();
        @(posedge clk);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        fire();
        @(posedge clk);
        check("wake pulse", wake, hit() && slp);
        irqchk();
    endtask

    task automatic do_reset(input bit pwr);
        rst_n <= 1'b0;
        pwr_n <= !pwr;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        pwr_n <= 1'b1;
        mctrl &= 8'h38;
        aen = 0;
        mask = 0;
        st = 0;
        if (pwr) begin
            {alarm_second_ones, alarm_minute_ones, ahour, awd, flag, wakec, mctrl} = '0;
        end
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            mains <= 1'b1;
            repeat (4) @(posedge clk);
            mains <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        static logic [7:0] tbl [8] = '{8'h00, 8'h12, 8'h24, 8'h48, 8'h81, 8'hf0, 8'hf4, 8'h51};
        void'($urandom(32'h2147));
        do_reset(1'b1);
        rd(IDX_CTRL);
        rd(IDX_ALARM_EN);
        rd(8'h10);
        wr(IDX_CTRL, 8'hff);
        mode();
        rd(IDX_CTRL);
        wr(IDX_ALARM_WEEKDAY, 8'hf5);
        rd(IDX_ALARM_WEEKDAY);
        wr(IDX_CTRL, 8'h78);
        mode();
        wr(IDX_ALARM_WEEKDAY, 8'h03);
        rd(IDX_ALARM_WEEKDAY);
        wr(IDX_ALARM_EN, 8'hff);
        rd(IDX_ALARM_EN);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_ALARM_SEC + 8'(i), 8'($urandom));
            rd(IDX_ALARM_SEC + 8'(i));
        end
        do_reset(1'b0);
        for (int i = 0; i < 6; i++) rd(IDX_ALARM_SEC + 8'(i));
        $display("test register access done");
        wr(IDX_CTRL, 8'h41);
        wr(IDX_ALARM_WEEKDAY, 8'h06);
        wr(IDX_ALARM_SEC, 8'h12);
        wr(IDX_ALARM_MIN, 8'h34);
        wr(IDX_ALARM_HOUR, 8'h05);
        wr(IDX_CTRL, 8'h40);
        mode();
        wr(IDX_IRQ_MASK, 8'h03);
        foreach (tbl[i]) begin
            wr(IDX_ALARM_EN, {4'h0, tbl[i][7:4]});
            nsec <= 8'h12 ^ {7'h0, tbl[i][0]};
            nmin <= 8'h34 ^ {7'h0, tbl[i][1]};
            nhour <= 8'h05 ^ {7'h0, tbl[i][2]};
            nwd <= 8'h06 ^ {7'h0, tbl[i][3]};
            evt();
            rd(IDX_CTRL);
            irqchk();
            rd(IDX_CTRL);
        end
        nsec <= 8'h12;
        wr(IDX_ALARM_EN, 8'h0f);
        wr(IDX_CTRL, 8'h00);
        evt();
        rd(IDX_CTRL);
        wr(IDX_CTRL, 8'h40);
        wr(IDX_IRQ_MASK, 8'h00);
        evt();
        rd(IDX_IRQ_STATUS);
        rd(IDX_CTRL);
        wr(IDX_IRQ_MASK, 8'h03);
        wr(IDX_CTRL, 8'h41);
        rd(IDX_CTRL);
        wr(IDX_CTRL, 8'h40);
        rd(IDX_CTRL);
        slp <= 1'b1;
        evt();
        slp <= 1'b0;
        do_reset(1'b0);
        rd(IDX_CTRL);
        rd(IDX_CTRL);
        $display("test alarm and interrupt done");
        for (int r = 0; r < 2; r++) begin
            wr(IDX_CTRL, 8'h10 | 8'(r << 3));
            mode();
            for (int k = 0; k < 2; k++) begin
                ticks = 0;
                pulses(int'(r ? DIV_MAINS_50 : DIV_MAINS_60) - 1);
                check("ticks short", ticks, 0);
                pulses(1);
                check("ticks full", ticks, 1);
                pulses(20);
                wr(IDX_CTRL, 8'h10 | 8'(r << 3));
            end
        end
        $display("test prescaler done");
        summarize();
    end
endmodule
